// ---- rtl/spc_pkg.sv ----
// Package for the pixel clock tree: register map, field positions, modes and dividers
// Behaviour
// - Oscillator clock is reference divided then multiplied; further dividers make the rest.
// - Two readout paths; row of 1248 path clocks gives 2304 pixels; receiver sees double.
// - In parallel mode the serial bit, lane and per-lane output clocks stay unused.
// - Serial per-lane output clock comes from output system and pixel dividers.
// - Serial link carries two bits per lane clock toggle; lane clock is a quarter of the bit rate.
// - Parallel port drives frame valid, line valid, pixel clock and 12-bit data outputs.
// - Parallel port stays disabled after reset until software enables it.
// - Output mode follows serializer-disable and parallel-enable control bits.
// - Serial format register selects 1, 2 or 4 MIPI lanes, or 4 differential lanes.
package spc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DIV_W = 8;
  localparam int PIX_W = 12;
  localparam int LANES = 4;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FORMAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRE_DIV = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MULT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_RO_SYS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RO_PIX = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_OP_SYS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_OP_PIX = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_LINE_LEN = 8'h24;
  // Control fields
  localparam int CTRL_SER_DIS = 12;
  localparam int CTRL_PAR_EN = 7;
  localparam int CTRL_STREAM = 2;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  // Serial formats
  localparam logic [DATA_W-1:0] FMT_MIPI1 = 16'h0201;
  localparam logic [DATA_W-1:0] FMT_MIPI2 = 16'h0202;
  localparam logic [DATA_W-1:0] FMT_MIPI4 = 16'h0204;
  localparam logic [DATA_W-1:0] FMT_DIFF4 = 16'h0304;
  localparam logic [DATA_W-1:0] FMT_RESET = FMT_MIPI4;
  // Divider reset values (recommended four-lane 12-bit)
  localparam logic [DIV_W-1:0] PRE_DIV_RESET = 8'h01;
  localparam logic [DIV_W-1:0] MULT_RESET = 8'h02;
  localparam logic [DIV_W-1:0] RO_SYS_RESET = 8'h01;
  localparam logic [DIV_W-1:0] RO_PIX_RESET = 8'h06;
  localparam logic [DIV_W-1:0] OP_SYS_RESET = 8'h01;
  localparam logic [DIV_W-1:0] OP_PIX_RESET = 8'h0c;
  // Row timing
  localparam logic [11:0] LINE_LEN_RESET = 12'h4e0;
  localparam logic [11:0] ACTIVE_PIX = 12'h900;
  localparam logic [11:0] ACTIVE_PER_PATH = 12'h480;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  // Settle time of the loop, in cycles of the 40 MHz clock
  localparam int SETTLE_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    SPC_MODE_OFF = 2'b00,
    SPC_MODE_SER = 2'b01,
    SPC_MODE_PAR = 2'b10
  } spc_mode_t;

  typedef struct packed {
    logic frame_valid_out;
    logic line_valid_out;
    logic parallel_pixel_clock;
    logic [PIX_W-1:0] data;
  } spc_par_t;

  typedef struct packed {
    logic lane_clock;
    logic [LANES-1:0] lane_en;
    logic per_lane_output_clock;
  } spc_ser_t;
endpackage

// ---- rtl/spc_div.sv ----
// Programmable clock-enable divider, one tick every div input ticks
`timescale 1ns/1ps
module spc_div
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic tick_in,
  input wire logic [DIV_W-1:0] div,
  // Result
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_reg;

  // A divider of zero acts as one so the chain never stalls
  always_ff @(posedge clk_sys)
  begin
    if (reset || !run)
    begin
      cnt_reg <= '0;
      tick_out <= 1'b0;
    end
    else if (tick_in)
    begin
      if (cnt_reg + 8'h01 >= div)
      begin
        cnt_reg <= '0;
        tick_out <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg + 8'h01;
        tick_out <= 1'b0;
      end
    end
    else
      tick_out <= 1'b0;
  end
endmodule

// ---- rtl/spc_row.sv ----
// Per-path row counter for one readout path
`timescale 1ns/1ps
module spc_row
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic [11:0] line_len,
  // State
  output logic [11:0] pos,
  output logic active,
  output logic row_end
);
  always_ff @(posedge clk_sys)
  begin
    if (reset || !run)
    begin
      pos <= '0;
      active <= 1'b0;
      row_end <= 1'b0;
    end
    else if (tick)
    begin
      row_end <= (pos == line_len - 12'h001);
      if (pos == line_len - 12'h001)
        pos <= '0;
      else
        pos <= pos + 12'h001;
      active <= (pos < ACTIVE_PER_PATH);
    end
    else
      row_end <= 1'b0;
  end
endmodule

// ---- rtl/spc_clock_tree.sv ----
// Top of the pixel clock tree: registers, divider chain, output mode and ports
`timescale 1ns/1ps
module spc_clock_tree
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Pixel source
  input wire logic [PIX_W-1:0] pixel_in,
  // Parallel port
  output spc_par_t par_out,
  // Serial port
  output spc_ser_t ser_out,
  output logic [1:0] lane_bits,
  // Status
  output logic clocks_valid,
  output logic [11:0] receiver_row_clocks
);
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] format_reg;
  logic [DIV_W-1:0] pre_div_reg;
  logic [DIV_W-1:0] mult_reg;
  logic [DIV_W-1:0] ro_sys_reg;
  logic [DIV_W-1:0] ro_pix_reg;
  logic [DIV_W-1:0] op_sys_reg;
  logic [DIV_W-1:0] op_pix_reg;
  logic [11:0] line_len_reg;
  spc_mode_t mode_reg;
  spc_mode_t mode_next;
  logic [7:0] settle_reg;
  logic stream;
  logic ser_dis;
  logic par_en;
  logic [LANES-1:0] lanes_next;
  logic pre_tick;
  logic osc_tick;
  logic [DIV_W-1:0] mult_cnt_reg;
  logic ro_sys_tick;
  logic pix_tick;
  logic op_sys_tick;
  logic op_tick;
  logic [1:0] path_active;
  logic [1:0] path_end;
  logic [11:0] pos_a;
  logic [11:0] pos_b;
  logic frame_reg;

  assign stream = ctrl_reg[CTRL_STREAM];
  assign ser_dis = ctrl_reg[CTRL_SER_DIS];
  assign par_en = ctrl_reg[CTRL_PAR_EN];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_reg <= CTRL_RESET;
      format_reg <= FMT_RESET;
      pre_div_reg <= PRE_DIV_RESET;
      mult_reg <= MULT_RESET;
      ro_sys_reg <= RO_SYS_RESET;
      ro_pix_reg <= RO_PIX_RESET;
      op_sys_reg <= OP_SYS_RESET;
      op_pix_reg <= OP_PIX_RESET;
      line_len_reg <= LINE_LEN_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFF_CTRL: ctrl_reg <= reg_wdata;
        OFF_FORMAT: format_reg <= reg_wdata;
        OFF_PRE_DIV: pre_div_reg <= reg_wdata[DIV_W-1:0];
        OFF_MULT: mult_reg <= reg_wdata[DIV_W-1:0];
        OFF_RO_SYS: ro_sys_reg <= reg_wdata[DIV_W-1:0];
        OFF_RO_PIX: ro_pix_reg <= reg_wdata[DIV_W-1:0];
        OFF_OP_SYS: op_sys_reg <= reg_wdata[DIV_W-1:0];
        OFF_OP_PIX: op_pix_reg <= reg_wdata[DIV_W-1:0];
        OFF_LINE_LEN: line_len_reg <= reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys)
  begin
    if (reset || !reg_rd)
      reg_rdata <= DATA_ZERO;
    else
    begin
      case (reg_addr)
        OFF_CTRL: reg_rdata <= ctrl_reg;
        OFF_FORMAT: reg_rdata <= format_reg;
        OFF_PRE_DIV: reg_rdata <= {8'h00, pre_div_reg};
        OFF_MULT: reg_rdata <= {8'h00, mult_reg};
        OFF_RO_SYS: reg_rdata <= {8'h00, ro_sys_reg};
        OFF_RO_PIX: reg_rdata <= {8'h00, ro_pix_reg};
        OFF_OP_SYS: reg_rdata <= {8'h00, op_sys_reg};
        OFF_OP_PIX: reg_rdata <= {8'h00, op_pix_reg};
        OFF_LINE_LEN: reg_rdata <= {4'h0, line_len_reg};
        OFF_STATUS: reg_rdata <= {12'h000, clocks_valid, frame_reg, mode_reg};
        default: reg_rdata <= DATA_ZERO;
      endcase
    end
  end

  always_comb
  begin
    if (ser_dis && par_en)
      mode_next = SPC_MODE_PAR;
    else if (!ser_dis && !par_en)
      mode_next = SPC_MODE_SER;
    else
      mode_next = SPC_MODE_OFF;
  end

  always_comb
  begin
    case (format_reg)
      FMT_MIPI1: lanes_next = 4'h1;
      FMT_MIPI2: lanes_next = 4'h3;
      FMT_MIPI4: lanes_next = 4'hf;
      FMT_DIFF4: lanes_next = 4'hf;
      default: lanes_next = 4'h0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      mode_reg <= SPC_MODE_OFF;
    else
    begin
      case (mode_next)
        SPC_MODE_SER: mode_reg <= SPC_MODE_SER;
        SPC_MODE_PAR: mode_reg <= SPC_MODE_PAR;
        default: mode_reg <= SPC_MODE_OFF;
      endcase
    end
  end

  spc_div u_pre (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(stream),
    .tick_in(1'b1),
    .div(pre_div_reg),
    .tick_out(pre_tick)
  );

  always_ff @(posedge clk_sys)
  begin
    if (reset || !stream)
      mult_cnt_reg <= '0;
    else if (pre_tick)
      mult_cnt_reg <= mult_reg;
    else if (mult_cnt_reg != 8'h00)
      mult_cnt_reg <= mult_cnt_reg - 8'h01;
  end
  assign osc_tick = (mult_cnt_reg != 8'h00);

  spc_div u_ro_sys (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(stream),
    .tick_in(osc_tick),
    .div(ro_sys_reg),
    .tick_out(ro_sys_tick)
  );

  spc_div u_ro_pix (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(stream),
    .tick_in(ro_sys_tick),
    .div(ro_pix_reg),
    .tick_out(pix_tick)
  );

  // output dividers idle in parallel mode
  spc_div u_op_sys (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(stream && mode_reg == SPC_MODE_SER),
    .tick_in(osc_tick),
    .div(op_sys_reg),
    .tick_out(op_sys_tick)
  );

  spc_div u_op_pix (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(stream && mode_reg == SPC_MODE_SER),
    .tick_in(op_sys_tick),
    .div(op_pix_reg),
    .tick_out(op_tick)
  );

  spc_row u_path_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(stream),
    .tick(pix_tick),
    .line_len(line_len_reg),
    .pos(pos_a),
    .active(path_active[0]),
    .row_end(path_end[0])
  );

  spc_row u_path_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(stream),
    .tick(pix_tick),
    .line_len(line_len_reg),
    .pos(pos_b),
    .active(path_active[1]),
    .row_end(path_end[1])
  );

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      receiver_row_clocks <= '0;
    else
      receiver_row_clocks <= {line_len_reg[10:0], 1'b0};
  end

  // Clocks are reported valid only after the settle count
  always_ff @(posedge clk_sys)
  begin
    if (reset || !stream || reg_wr)
      settle_reg <= '0;
    else if (settle_reg != SETTLE_CYC[7:0])
      settle_reg <= settle_reg + 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      clocks_valid <= 1'b0;
    else
      clocks_valid <= (settle_reg == SETTLE_CYC[7:0]);
  end

  always_ff @(posedge clk_sys)
    frame_reg <= stream && !reset;

  always_ff @(posedge clk_sys)
  begin
    if (reset || mode_reg != SPC_MODE_PAR || !clocks_valid)
      par_out <= '0;
    else
    begin
      par_out.frame_valid_out <= frame_reg;
      par_out.line_valid_out <= path_active[0] | path_active[1];
      if (pix_tick)
        par_out.parallel_pixel_clock <= ~par_out.parallel_pixel_clock;
      par_out.data <= pixel_in;
    end
  end

  // lane clock toggles, two bits a toggle
  always_ff @(posedge clk_sys)
  begin
    if (reset || mode_reg != SPC_MODE_SER || !clocks_valid)
    begin
      ser_out <= '0;
      lane_bits <= 2'b00;
    end
    else
    begin
      ser_out.lane_en <= lanes_next;
      ser_out.per_lane_output_clock <= op_tick;
      if (op_tick)
      begin
        ser_out.lane_clock <= ~ser_out.lane_clock;
        lane_bits <= {pixel_in[PIX_W-1], pixel_in[PIX_W-2]};
      end
    end
  end

  // no parallel activity outside parallel mode
  AST_PAR_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_reg != SPC_MODE_PAR) |=> (par_out == '0))
    else $error("parallel port active outside parallel mode");
  AST_SER_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_reg == SPC_MODE_PAR) |=> (ser_out == '0 && lane_bits == 2'b00))
    else $error("serial clocks running in parallel mode");
  sequence seq_par_req;
    (ser_dis && par_en) ##1 (ser_dis && par_en);
  endsequence
  AST_MODE: assert property (@(posedge clk_sys) disable iff (reset)
    seq_par_req |-> (mode_reg == SPC_MODE_PAR))
    else $error("mode does not follow control bits");
  AST_ONE_LANE: assert property (@(posedge clk_sys) disable iff (reset)
    (ser_out.lane_en != 4'h0) |-> ($past(format_reg) != FMT_MIPI1 || ser_out.lane_en == 4'h1))
    else $error("lane enables disagree with format");
  AST_PATHS: assert property (@(posedge clk_sys) disable iff (reset)
    (pos_a == pos_b) && (path_end[0] == path_end[1]))
    else $error("readout paths out of step");
  // per-lane clock only follows output divider
  AST_OPCLK: assert property (@(posedge clk_sys) disable iff (reset)
    ser_out.per_lane_output_clock |-> $past(op_tick))
    else $error("lane output clock without divider tick");
  // oscillator ticks follow a pre-divided tick
  AST_OSC: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(osc_tick) |-> $past(pre_tick))
    else $error("oscillator tick without pre-divided tick");
  // lane clock changes only on divider ticks or when cleared outside serial mode or before clocks are valid
  AST_LANECLK: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(ser_out.lane_clock) |-> ($past(op_tick) || $past(mode_reg) != SPC_MODE_SER || !$past(clocks_valid)))
    else $error("lane clock toggled without tick");
  // line valid only with frame valid
  AST_LV_FV: assert property (@(posedge clk_sys) disable iff (reset)
    par_out.line_valid_out |-> par_out.frame_valid_out)
    else $error("line valid outside frame");
endmodule

// ---- tb/spc_rx_model.sv ----
// Receiver model that counts clocks and captures lane bits
`timescale 1ns/1ps
module spc_rx_model
  import spc_pkg::*;
(
  // Clock and clear
  input wire logic clk_sys,
  input wire logic clear,
  // Streams from the block
  input wire spc_par_t par_out,
  input wire spc_ser_t ser_out,
  input wire logic [1:0] lane_bits,
  // Counts seen
  output int n_pix_clk,
  output int n_lane_tick,
  output int n_lane_tog,
  output logic [1:0] last_bits
);
  logic pclk_d = 1'b0;
  logic lclk_d = 1'b0;
  // pixel clock edges, two bits per lane tick
  always @(posedge clk_sys)
  begin
    pclk_d <= par_out.parallel_pixel_clock;
    lclk_d <= ser_out.lane_clock;
    if (clear)
    begin
      n_pix_clk <= 0;
      n_lane_tick <= 0;
      n_lane_tog <= 0;
    end
    else
    begin
      if (par_out.parallel_pixel_clock && !pclk_d)
        n_pix_clk <= n_pix_clk + 1;
      if (ser_out.per_lane_output_clock)
        n_lane_tick <= n_lane_tick + 1;
      if (ser_out.per_lane_output_clock)
        last_bits <= lane_bits;
      if (ser_out.lane_clock !== lclk_d)
        n_lane_tog <= n_lane_tog + 1;
    end
  end
endmodule

// ---- tb/spc_clock_tree_tb.sv ----
// Self-checking bench for the pixel clock tree
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
      n_errors++; \
    end \
  end
module spc_clock_tree_tb
  import spc_pkg::*;
;
  typedef struct {logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] val;} spc_reg_row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [PIX_W-1:0] pixel_in = 12'ha5c;
  spc_par_t par_out;
  spc_ser_t ser_out;
  logic [1:0] lane_bits;
  logic clocks_valid;
  logic [11:0] receiver_row_clocks;
  logic clr = 1'b1;
  int n_pix_clk;
  int n_lane_tick;
  int n_lane_tog;
  logic [1:0] last_bits;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  spc_reg_row_t rows [11];
  logic [DATA_W-1:0] fmts [5];
  logic [LANES-1:0] lanes [5];
  logic [DATA_W-1:0] d;
  int a;
  int b;
  int c;

  spc_clock_tree DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pixel_in(pixel_in), .par_out(par_out),
    .ser_out(ser_out), .lane_bits(lane_bits), .clocks_valid(clocks_valid),
    .receiver_row_clocks(receiver_row_clocks));

  spc_rx_model rx (.clk_sys(clk_sys), .clear(clr), .par_out(par_out), .ser_out(ser_out),
    .lane_bits(lane_bits), .n_pix_clk(n_pix_clk), .n_lane_tick(n_lane_tick), .n_lane_tog(n_lane_tog),
    .last_bits(last_bits));

  always #12.5 clk_sys = ~clk_sys;

  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Runaway guard, the whole sequence needs well under this
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic reg_write(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= wd;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] ad, output logic [DATA_W-1:0] rd);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic wait_valid();
    int k;
    k = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    while (clocks_valid !== 1'b1 && k < 200)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    `CHK(clocks_valid, 1'b1)
  endtask

  task automatic clear_counts();
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
  endtask

  // Lane ticks over a fixed window for one divider setting
  task automatic measure(input logic [DIV_W-1:0] pre, input logic [DIV_W-1:0] op, output int n);
    reg_write(OFF_CTRL, 16'h0000);
    reg_write(OFF_PRE_DIV, {8'h00, pre});
    reg_write(OFF_OP_PIX, {8'h00, op});
    reg_write(OFF_CTRL, 16'h0004);
    wait_valid();
    clear_counts();
    repeat (600) @(posedge clk_sys);
    #1 n = n_lane_tick;
  endtask

  initial
  begin
    rows = '{'{OFF_CTRL, 16'h0000}, '{OFF_FORMAT, 16'h0204}, '{OFF_PRE_DIV, 16'h0001},
      '{OFF_MULT, 16'h0002}, '{OFF_RO_SYS, 16'h0001}, '{OFF_RO_PIX, 16'h0006}, '{OFF_OP_SYS, 16'h0001},
      '{OFF_OP_PIX, 16'h000c}, '{OFF_LINE_LEN, 16'h04e0}, '{OFF_STATUS, 16'h0001}, '{8'h30, 16'h0000}};
    fmts = '{16'h0201, 16'h0202, 16'h0204, 16'h0304, 16'h0305};
    lanes = '{4'h1, 4'h3, 4'hf, 4'hf, 4'h0};
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    clr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(par_out, 15'h0000)
    `CHK(receiver_row_clocks, 12'h9c0)
    // Reset values, status and an unmapped place
    for (int i = 0; i < 11; i++)
    begin
      reg_read(rows[i].addr, d);
      `CHK(d, rows[i].val)
    end
    // Status is read-only
    reg_write(OFF_STATUS, 16'h000f);
    reg_read(OFF_STATUS, d);
    `CHK(d, 16'h0001)
    reg_write(OFF_LINE_LEN, 16'h0064);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(receiver_row_clocks, 12'h0c8)
    // reset dividers keep readout at twice the output rate
    reg_write(OFF_CTRL, 16'h1084);
    wait_valid();
    reg_read(OFF_STATUS, d);
    `CHK(d & 16'h000b, 16'h000a)
    clear_counts();
    repeat (200) @(posedge clk_sys);
    #1;
    `CHK(n_pix_clk > 0, 1'b1)
    `CHK(n_pix_clk inside {[16:17]}, 1'b1)
    `CHK(par_out.data, 12'ha5c)
    `CHK({par_out.frame_valid_out, par_out.line_valid_out}, 2'b11)
    `CHK(n_lane_tick, 0)
    `CHK(ser_out, 6'h00)
    // Second reset while parallel output runs
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(par_out, 15'h0000)
    reg_read(OFF_CTRL, d);
    `CHK(d, 16'h0000)
    // Mixed control bits give no output
    for (int i = 0; i < 2; i++)
    begin
      reg_write(OFF_CTRL, (i == 0) ? 16'h1004 : 16'h0084);
      repeat (60) @(posedge clk_sys);
      reg_read(OFF_STATUS, d);
      `CHK(d & 16'h0003, 16'h0000)
      `CHK(par_out, 15'h0000)
      `CHK(ser_out, 6'h00)
    end
    // Every serial format, then an unknown one
    for (int i = 0; i < 5; i++)
    begin
      reg_write(OFF_CTRL, 16'h0000);
      reg_write(OFF_FORMAT, fmts[i]);
      reg_write(OFF_CTRL, 16'h0004);
      repeat (60) @(posedge clk_sys);
      #1;
      `CHK(ser_out.lane_en, lanes[i])
      `CHK(par_out, 15'h0000)
    end
    reg_read(OFF_STATUS, d);
    `CHK(d & 16'h0003, 16'h0001)
    // four lanes, output dividers 1 and 12 at base
    reg_write(OFF_FORMAT, 16'h0204);
    measure(8'h02, 8'h0c, a);
    `CHK(a > 0, 1'b1)
    `CHK((n_lane_tog - n_lane_tick) inside {-1, 0, 1}, 1'b1)
    `CHK(last_bits, 2'b10)
    // halving the output pixel divider doubles the lane rate; doubling the pre-divider halves it
    measure(8'h02, 8'h06, b);
    `CHK((b - 2 * a) inside {[-2:2]}, 1'b1)
    measure(8'h04, 8'h0c, c);
    `CHK((2 * c - a) inside {[-2:2]}, 1'b1)
    end_of_test();
  end
endmodule
